// ---- dbgpri_pkg.sv ----
// Shared constants and types of the debug entry and boundary scan block.
// Assumes one core clock domain and one scan test clock domain.
package dbgpri_pkg;

  // ==========================================================================
  // Boundary scan chain layout, printed cell positions (position 1 first)
  localparam int CHAIN_LEN = 105;
  localparam int POS_DATA0 = 1;
  localparam int POS_BREAKPOINT_FLAG_INPUT = 33;
  localparam int POS_DIN_EN_N = 34;
  localparam int POS_DOUT_EN_N = 35;
  localparam int POS_LOCK = 36;
  localparam int POS_ENDIAN = 37;
  localparam int POS_DBUS_EN = 38;
  localparam int POS_SIZE0 = 39;
  localparam int POS_BYTE_LATCH0 = 41;
  localparam int POS_MISC0 = 45;
  localparam int MISC_CELLS = 29;
  localparam int POS_ADDR31 = 74;

  // ==========================================================================
  // Program counter steps, in word addresses
  localparam logic [31:0] PC_RESET = 32'h0000_0000;
  localparam logic [31:0] PC_STEP_BREAK = 32'h0000_0004;
  localparam logic [31:0] PC_STEP_REQUEST = 32'h0000_0003;
  localparam logic [31:0] PC_STEP_EXCEPT = 32'h0000_0003;
  localparam logic [31:0] PC_STEP_SYSTEM = 32'h0000_0003;
  localparam logic [31:0] PC_STEP_INSTR = 32'h0000_0001;

  // ==========================================================================
  // Test access port instructions
  localparam int IR_WIDTH = 4;
  localparam logic [IR_WIDTH-1:0] IR_EXTEST = 4'h0;
  localparam logic [IR_WIDTH-1:0] IR_RESTART = 4'h4;
  localparam logic [IR_WIDTH-1:0] IR_INTEST = 4'hc;
  localparam logic [IR_WIDTH-1:0] IR_BYPASS = 4'hf;
  localparam logic [IR_WIDTH-1:0] IR_CAPTURE = 4'h1;

  // ==========================================================================
  // State and mode encodings
  typedef enum logic [3:0] {
    TAP_RESET = 4'hf, TAP_RTI = 4'hc, TAP_SEL_DR = 4'h7, TAP_CAP_DR = 4'h6,
    TAP_SHIFT_DR = 4'h2, TAP_EX1_DR = 4'h1, TAP_PAUSE_DR = 4'h3,
    TAP_EX2_DR = 4'h0, TAP_UPD_DR = 4'h5, TAP_SEL_IR = 4'h4,
    TAP_CAP_IR = 4'he, TAP_SHIFT_IR = 4'ha, TAP_EX1_IR = 4'h9,
    TAP_PAUSE_IR = 4'hb, TAP_EX2_IR = 4'h8, TAP_UPD_IR = 4'hd
  } dbgpri_tap_e;

  typedef enum logic [2:0] {
    CORE_RUN = 3'h0, CORE_HOLD = 3'h1, CORE_DEBUG = 3'h3,
    CORE_SYS = 3'h2, CORE_SYS_ABORT = 3'h6
  } dbgpri_core_e;

  typedef enum logic [1:0] {
    MODE_PROGRAM = 2'h0, MODE_IRQ = 2'h1, MODE_ABORT = 2'h2
  } dbgpri_mode_e;

endpackage : dbgpri_pkg

// ---- dbgpri_link_if.sv ----
// Carrier between the core-side logic and the scan-clock logic.
// Assumes each signal is driven in one domain; cap, tap_rst_req and restart_tgl are crossed in the other.
`timescale 1ns/1ps
`default_nettype none
interface dbgpri_link_if
  import dbgpri_pkg::*;
;
  logic [CHAIN_LEN-1:0] cap;
  logic [CHAIN_LEN-1:0] upd;
  logic tap_rst_req;
  logic restart_tgl;
  logic tdo;
  logic pin_oe_n;

  modport core (output cap, output tap_rst_req, input upd,
                input restart_tgl, input tdo, input pin_oe_n);
  modport scan (input cap, input tap_rst_req, output upd,
                output restart_tgl, output tdo, output pin_oe_n);
endinterface : dbgpri_link_if
`default_nettype wire

// ---- dbgpri_scan.sv ----
// Test access port controller and boundary scan register on the scan clock.
// Assumes the capture word and reset request arrive from the core clock.
`timescale 1ns/1ps
`default_nettype none
module dbgpri_scan
  import dbgpri_pkg::*;
(
  // Scan clock and serial port
  input wire logic scan_test_clock_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  // Core side
  dbgpri_link_if.scan link
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic [CHAIN_LEN-1:0] cap_s1;
    logic [CHAIN_LEN-1:0] cap_s2;
    dbgpri_tap_e tap;
    logic [IR_WIDTH-1:0] ir;
    logic [IR_WIDTH-1:0] ir_sh;
    logic [CHAIN_LEN-1:0] sh;
    logic [CHAIN_LEN-1:0] upd;
    logic byp;
    logic tdo;
    logic rtgl;
    logic oe_n;
  } dbgpri_scan_s;

  dbgpri_scan_s st;
  dbgpri_scan_s nx;

  // Standard controller walk on the mode select level.
  function automatic dbgpri_tap_e tap_next(input dbgpri_tap_e s,
                                           input logic tms);
    unique case (s)
      TAP_RESET: tap_next = tms ? TAP_RESET : TAP_RTI;
      TAP_RTI: tap_next = tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = tms ? TAP_EX1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: tap_next = tms ? TAP_EX1_DR : TAP_SHIFT_DR;
      TAP_EX1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: tap_next = tms ? TAP_EX2_DR : TAP_PAUSE_DR;
      TAP_EX2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: tap_next = tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_IR: tap_next = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = tms ? TAP_EX1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: tap_next = tms ? TAP_EX1_IR : TAP_SHIFT_IR;
      TAP_EX1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: tap_next = tms ? TAP_EX2_IR : TAP_PAUSE_IR;
      TAP_EX2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: tap_next = tms ? TAP_SEL_DR : TAP_RTI;
    endcase
  endfunction : tap_next

  // ==========================================================================
  // Next state. The capture word is quasi-static, so a two-stage sync of
  // the whole word is enough; a bit caught mid-change reads old or new.
  always_comb
  begin
    logic bsel;
    bsel = (st.ir == IR_EXTEST) || (st.ir == IR_INTEST);
    nx = st;
    nx.rst_s1 = link.tap_rst_req;
    nx.rst_s2 = st.rst_s1;
    nx.cap_s1 = link.cap;
    nx.cap_s2 = st.cap_s1;
    nx.tap = tap_next(st.tap, tms_in);
    unique case (st.tap)
      TAP_RESET: nx.ir = IR_BYPASS;
      TAP_CAP_DR:
      begin
        if (bsel)
          nx.sh = st.cap_s2;
        nx.byp = 1'b0;
      end
      TAP_SHIFT_DR:
      begin
        // Cell 1 sits next to the serial input, the last cell drives out.
        if (bsel)
          nx.sh = {st.sh[CHAIN_LEN-2:0], tdi_in};
        nx.byp = tdi_in;
        nx.tdo = bsel ? st.sh[CHAIN_LEN-1] : st.byp;
      end
      TAP_UPD_DR:
      begin
        if (bsel)
          nx.upd = st.sh;
      end
      TAP_CAP_IR: nx.ir_sh = IR_CAPTURE;
      TAP_SHIFT_IR:
      begin
        nx.ir_sh = {tdi_in, st.ir_sh[IR_WIDTH-1:1]};
        nx.tdo = st.ir_sh[0];
      end
      TAP_UPD_IR: nx.ir = st.ir_sh;
      TAP_RTI, TAP_SEL_DR, TAP_EX1_DR, TAP_PAUSE_DR, TAP_EX2_DR,
      TAP_SEL_IR, TAP_EX1_IR, TAP_PAUSE_IR, TAP_EX2_IR: ;
    endcase
    // Resume is signalled on arrival in run-test-idle under restart. The
    // incoming instruction counts, so a load of restart resumes at once.
    if (nx.tap == TAP_RTI && st.tap != TAP_RTI && nx.ir == IR_RESTART)
      nx.rtgl = !st.rtgl;
    nx.oe_n = !(nx.ir == IR_EXTEST && !nx.upd[POS_DOUT_EN_N-1]);
    if (st.rst_s2)
    begin
      nx.tap = TAP_RESET;
      nx.ir = IR_BYPASS;
      nx.ir_sh = IR_CAPTURE;
      nx.sh = '0;
      nx.upd = '0;
      nx.byp = 1'b0;
      nx.tdo = 1'b0;
      nx.rtgl = 1'b0;
      nx.oe_n = 1'b1;
    end
  end

  // Registers, all on the rising scan clock edge.
  always_ff @(posedge scan_test_clock_in)
  begin
    st <= nx;
  end

  assign link.upd = st.upd;
  assign link.restart_tgl = st.rtgl;
  assign link.tdo = st.tdo;
  assign link.pin_oe_n = st.oe_n;

endmodule : dbgpri_scan
`default_nettype wire

// ---- dbgpri_core.sv ----
// Debug entry priority and program counter tracking for the core, with the
// boundary scan chain and its access port on the scan test clock.
// Assumes watch unit, fetch and memory status come from the core clock;
// the debug request pin and the scan port come from outside it.
//
// How it works
// - Request entry adds three; each instruction one.
// - System-speed access adds three to counter.
// - Aborted system access: abort mode, then debug.
// - Prefetch abort beats breakpoint on same fetch.
// - Refetched breakpointed instruction enters debug when matched.
// - Debug entry disables interrupts automatically.
// - Pending interrupts matter only for watchpoint and request entries.
// - Pending interrupt makes watchpoint or request entry use its mode.
// - Debug beats interrupt; interrupt still remembered on watchpoint or request entry.
// - Watched data abort: abort mode, abort remembered.
// - Signals latch on core clock rise; test capture loads them on scan clock rise.
// - Cells 1 to 32 are data bits ascending.
// - Cells 33 to 40 hold the control signals.
// - Byte latches at 41-44, address 74 to 105.
`timescale 1ns/1ps
`default_nettype none
module dbgpri_core
  import dbgpri_pkg::*;
(
  // Core clock and synchronous reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Serial scan port on the scan test clock
  input wire logic scan_test_clock_in,
  input wire logic scan_mode_select_in,
  input wire logic scan_data_in,
  output logic scan_data_out,
  // Debug entry events
  input wire logic debug_request_input_in,
  input wire logic breakpoint_flag_input_in,
  input wire logic watchpoint_hit_in,
  input wire logic fetch_valid_in,
  input wire logic prefetch_abort_in,
  input wire logic data_abort_in,
  input wire logic irq_pending_in,
  input wire logic exception_ack_in,
  // Execution while in debug state
  input wire logic debug_instr_done_in,
  input wire logic debug_branch_in,
  input wire logic [31:0] branch_back_in,
  input wire logic system_access_in,
  input wire logic system_done_in,
  input wire logic system_abort_in,
  // Pad and core signals seen by the boundary cells
  input wire logic [31:0] data_pin_in,
  input wire logic data_in_enable_n_in,
  input wire logic data_out_enable_n_in,
  input wire logic locked_transfer_in,
  input wire logic endianness_select_in,
  input wire logic data_bus_drive_enable_in,
  input wire logic [1:0] access_size_in,
  input wire logic [3:0] byte_latch_enable_in,
  input wire logic [MISC_CELLS-1:0] misc_cells_in,
  input wire logic [31:0] address_in,
  // Data pins driven from the boundary cells in external test
  output logic [31:0] data_pin_out,
  output logic data_pin_oe_n_out,
  // Debug status
  output logic [31:0] pc_out,
  output logic debug_ack_out,
  output logic [1:0] core_mode_out,
  output logic irq_disable_out,
  output logic irq_remembered_out,
  output logic abort_remembered_out,
  output logic prefetch_abort_take_out
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic rst_q;
    logic [1:0] req_sync;
    logic [2:0] rst_tgl;
    dbgpri_core_e st;
    dbgpri_mode_e mode;
    logic [31:0] pc;
    logic ack;
    logic irq_off;
    logic irq_rem;
    logic abt_rem;
    logic pabt;
    logic [CHAIN_LEN-1:0] cap;
  } dbgpri_core_s;

  dbgpri_core_s r;
  dbgpri_core_s nx;
  logic restart_ev;

  dbgpri_link_if link();

  // ==========================================================================
  // Scan-clock half: controller and boundary register.
  dbgpri_scan u_scan (
    .scan_test_clock_in(scan_test_clock_in),
    .tms_in(scan_mode_select_in),
    .tdi_in(scan_data_in),
    .link(link)
  );

  // The third toggle stage only feeds this edge detector; the first stage
  // is read by the second alone.
  assign restart_ev = r.rst_tgl[2] ^ r.rst_tgl[1];

  // ==========================================================================
  // Next state of the entry sequencer and the tracked program counter.
  always_comb
  begin
    nx = r;
    nx.rst_q = srst_in;
    nx.req_sync = {r.req_sync[0], debug_request_input_in};
    nx.rst_tgl = {r.rst_tgl[1:0], link.restart_tgl};
    nx.pabt = 1'b0;

    // Boundary capture word, index is position minus one.
    nx.cap = '0;
    nx.cap[POS_DATA0-1 +: 32] = data_pin_in;
    nx.cap[POS_BREAKPOINT_FLAG_INPUT-1] = breakpoint_flag_input_in;
    nx.cap[POS_DIN_EN_N-1] = data_in_enable_n_in;
    nx.cap[POS_DOUT_EN_N-1] = data_out_enable_n_in;
    nx.cap[POS_LOCK-1] = locked_transfer_in;
    nx.cap[POS_ENDIAN-1] = endianness_select_in;
    nx.cap[POS_DBUS_EN-1] = data_bus_drive_enable_in;
    nx.cap[POS_SIZE0-1 +: 2] = access_size_in;
    nx.cap[POS_BYTE_LATCH0-1 +: 4] = byte_latch_enable_in;
    nx.cap[POS_MISC0-1 +: MISC_CELLS] = misc_cells_in;
    for (int i = 0; i < 32; i++)
      nx.cap[POS_ADDR31-1+i] = address_in[31-i];

    // Remembered exceptions clear on service, but a new set wins.
    if (exception_ack_in)
    begin
      nx.irq_rem = 1'b0;
      nx.abt_rem = 1'b0;
    end

    unique case (r.st)
      CORE_RUN:
      begin
        if (watchpoint_hit_in)
        begin
          // A watched access with an exception switches mode first and
          // enters one cycle later.
          if (data_abort_in)
          begin
            nx.st = CORE_HOLD;
            nx.mode = MODE_ABORT;
            nx.abt_rem = 1'b1;
          end
          else if (irq_pending_in)
          begin
            nx.st = CORE_HOLD;
            nx.mode = MODE_IRQ;
            nx.irq_rem = 1'b1;
          end
          else
          begin
            nx.st = CORE_DEBUG;
            nx.pc = r.pc + PC_STEP_BREAK;
          end
        end
        else if (fetch_valid_in && prefetch_abort_in)
          nx.pabt = 1'b1;
        else if (fetch_valid_in && breakpoint_flag_input_in)
        begin
          // Pending interrupts are ignored on a breakpoint.
          nx.st = CORE_DEBUG;
          nx.pc = r.pc + PC_STEP_BREAK;
        end
        else if (r.req_sync[1])
        begin
          nx.st = CORE_DEBUG;
          nx.pc = r.pc + PC_STEP_REQUEST;
          if (irq_pending_in)
          begin
            nx.mode = MODE_IRQ;
            nx.irq_rem = 1'b1;
          end
        end
        else if (fetch_valid_in)
          nx.pc = r.pc + PC_STEP_INSTR;
      end
      CORE_HOLD:
      begin
        nx.st = CORE_DEBUG;
        nx.pc = r.pc + PC_STEP_EXCEPT;
      end
      CORE_DEBUG:
      begin
        if (restart_ev)
          nx.st = CORE_RUN;
        else if (system_access_in)
        begin
          nx.st = CORE_SYS;
          nx.pc = r.pc + PC_STEP_SYSTEM;
        end
        else if (debug_branch_in)
          nx.pc = r.pc - branch_back_in;
        else if (debug_instr_done_in)
          nx.pc = r.pc + PC_STEP_INSTR;
      end
      CORE_SYS:
      begin
        if (system_abort_in)
        begin
          nx.st = CORE_SYS_ABORT;
          nx.mode = MODE_ABORT;
        end
        else if (system_done_in)
          nx.st = CORE_DEBUG;
      end
      CORE_SYS_ABORT: nx.st = CORE_DEBUG;
      default: nx.st = CORE_RUN;
    endcase

    // Interrupts stay masked for the whole stay outside program run.
    nx.ack = (nx.st == CORE_DEBUG);
    nx.irq_off = (nx.st != CORE_RUN);

    if (srst_in)
    begin
      nx.req_sync = 2'h0;
      nx.rst_tgl = {3{link.restart_tgl}};
      nx.st = CORE_RUN;
      nx.mode = MODE_PROGRAM;
      nx.pc = PC_RESET;
      nx.ack = 1'b0;
      nx.irq_off = 1'b0;
      nx.irq_rem = 1'b0;
      nx.abt_rem = 1'b0;
      nx.pabt = 1'b0;
      nx.cap = '0;
    end
  end

  // Registers on the core clock.
  always_ff @(posedge clk_in)
  begin
    r <= nx;
  end

  // ==========================================================================
  // Outputs, each straight from a register.
  assign link.cap = r.cap;
  assign link.tap_rst_req = r.rst_q;
  assign scan_data_out = link.tdo;
  assign data_pin_out = link.upd[POS_DATA0-1 +: 32];
  assign data_pin_oe_n_out = link.pin_oe_n;
  assign pc_out = r.pc;
  assign debug_ack_out = r.ack;
  assign core_mode_out = r.mode;
  assign irq_disable_out = r.irq_off;
  assign irq_remembered_out = r.irq_rem;
  assign abort_remembered_out = r.abt_rem;
  assign prefetch_abort_take_out = r.pabt;

  // ==========================================================================
  // Checks on the core clock.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  sequence s_run_quiet;
    r.st == CORE_RUN && !watchpoint_hit_in;
  endsequence

  sequence s_sys_abort;
    r.st == CORE_SYS && system_abort_in;
  endsequence

  sequence s_watch_irq;
    r.st == CORE_RUN && watchpoint_hit_in && !data_abort_in &&
    irq_pending_in;
  endsequence

  chk_req_entry_pc: assert property (
    (r.st == CORE_RUN && !watchpoint_hit_in && r.req_sync[1] &&
     !(fetch_valid_in && (prefetch_abort_in || breakpoint_flag_input_in)))
    |=> debug_ack_out && pc_out == $past(pc_out) + PC_STEP_REQUEST)
    else $error("Request entry did not add three to the counter.");

  chk_req_irq_mode: assert property (
    (r.st == CORE_RUN && !watchpoint_hit_in && r.req_sync[1] &&
     !(fetch_valid_in && (prefetch_abort_in || breakpoint_flag_input_in)) &&
     irq_pending_in)
    |=> core_mode_out == MODE_IRQ && irq_remembered_out)
    else $error("Request entry with interrupt kept the program mode.");

  chk_instr_pc_step: assert property (
    (r.st == CORE_DEBUG && !restart_ev && !system_access_in &&
     !debug_branch_in && debug_instr_done_in)
    |=> debug_ack_out && pc_out == $past(pc_out) + PC_STEP_INSTR)
    else $error("Debug instruction did not add one to the counter.");

  chk_sys_pc_step: assert property (
    (r.st == CORE_DEBUG && !restart_ev && system_access_in)
    |=> !debug_ack_out && pc_out == $past(pc_out) + PC_STEP_SYSTEM)
    else $error("System access did not add three to the counter.");

  chk_sys_abort_mode: assert property (
    s_sys_abort |=> core_mode_out == MODE_ABORT && !debug_ack_out
    ##1 debug_ack_out)
    else $error("Aborted system access skipped abort mode.");

  chk_pabort_wins: assert property (
    (s_run_quiet and (fetch_valid_in && prefetch_abort_in))
    |=> prefetch_abort_take_out && !debug_ack_out)
    else $error("Breakpoint was not disregarded on prefetch abort.");

  chk_bp_entry: assert property (
    (s_run_quiet and (fetch_valid_in && !prefetch_abort_in &&
     breakpoint_flag_input_in))
    |=> debug_ack_out && pc_out == $past(pc_out) + PC_STEP_BREAK &&
        core_mode_out == $past(core_mode_out))
    else $error("Breakpoint entry was wrong.");

  chk_irq_masked: assert property (
    debug_ack_out |-> irq_disable_out)
    else $error("Interrupts were enabled in debug state.");

  chk_watch_irq_mode: assert property (
    s_watch_irq
    |=> core_mode_out == MODE_IRQ && irq_remembered_out && !debug_ack_out
    ##1 debug_ack_out)
    else $error("Watched interrupt entry was wrong.");

  chk_watch_abort: assert property (
    (r.st == CORE_RUN && watchpoint_hit_in && data_abort_in)
    |=> core_mode_out == MODE_ABORT && abort_remembered_out
    ##1 debug_ack_out && pc_out == $past(pc_out, 2) + PC_STEP_EXCEPT)
    else $error("Watched data abort entry was wrong.");

endmodule : dbgpri_core
`default_nettype wire

// ---- dbgpri_pkg_unused_guard.sv ----
// Holds no logic; the shared constants and types of the block live in the package.
// Assumes nothing of its surroundings.

// ---- dbgpri_tap_model.sv ----
// Debugger model driving the serial scan port of the core.
// Assumes scan data out changes just after each rising scan clock edge.
`timescale 1ns/1ps
`default_nettype none
module dbgpri_tap_model
  import dbgpri_pkg::*;
(
  // Serial port toward the core
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  input wire logic tdo_in
);
  // ==========================================================================
  // The clock only runs inside a frame, so it stands still when idle.
  initial
  begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
  end

  // One 12 ns period; data out is taken late in the high phase.
  task automatic tick(input logic m, input logic d, output logic o);
    tms_out = m;
    tdi_out = d;
    #6 tck_out = 1'b1;
    #5 o = tdo_in;
    #1 tck_out = 1'b0;
    tdi_out = ~d; // Held data no longer shows the old bit.
  endtask : tick

  // Five high mode bits reach the reset state from anywhere.
  task automatic reset();
    logic o;
    repeat (5) tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
  endtask : reset

  // Instruction load from idle, low bit first, ending back in idle.
  task automatic ir(input logic [IR_WIDTH-1:0] c);
    logic o;
    tick(1'b1, 1'b0, o);
    tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
    tick(1'b0, 1'b0, o);
    for (int i = 0; i < IR_WIDTH; i++)
      tick(i == IR_WIDTH - 1, c[i], o);
    tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
  endtask : ir

  // Data scan: the far cell leaves first, cell 1 is filled last.
  task automatic dr(input logic [104:0] v, output logic [104:0] q);
    logic o;
    tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
    tick(1'b0, 1'b0, o);
    for (int i = 104; i >= 0; i--)
      tick(i == 0, v[i], q[i]);
    tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
  endtask : dr
endmodule : dbgpri_tap_model
`default_nettype wire

// ---- test_dbgpri_core.sv ----
// Self-checking bench for the debug entry and boundary scan block.
// Assumes the debugger model owns the serial port and its clock.
`timescale 1ns/1ps
`default_nettype none
module test_dbgpri_core
  import dbgpri_pkg::*;
;
  // ==========================================================================
  // Stimulus, with one bit of ev for each pulsed event input.
  localparam logic [10:0] FV = 11'h001, BP = 11'h002, WP = 11'h004;
  localparam logic [10:0] PA = 11'h008, DA = 11'h010, DI = 11'h020;
  localparam logic [10:0] DB = 11'h040, SA = 11'h080, SD = 11'h100;
  localparam logic [10:0] SB = 11'h200, EA = 11'h400;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic dreq = 1'b0;
  logic irq = 1'b0;
  logic [10:0] ev = 11'h000;
  logic [10:0] cl = 11'h000;
  logic [28:0] mc = 29'h0;
  logic [31:0] br = 32'h0;
  logic [31:0] pd = 32'h0;
  logic [31:0] adr = 32'h0;
  logic [31:0] ep = 32'h0;
  logic tck, tms, tdi, tdo, ack, idis, irem, arem, ptk, oen;
  logic [31:0] pc, dpo;
  logic [1:0] mode;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;

  dbgpri_core dut (.clk_in(clk), .srst_in(srst),
    .scan_test_clock_in(tck), .scan_mode_select_in(tms),
    .scan_data_in(tdi), .scan_data_out(tdo),
    .debug_request_input_in(dreq), .breakpoint_flag_input_in(ev[1]),
    .watchpoint_hit_in(ev[2]), .fetch_valid_in(ev[0]),
    .prefetch_abort_in(ev[3]), .data_abort_in(ev[4]),
    .irq_pending_in(irq), .exception_ack_in(ev[10]),
    .debug_instr_done_in(ev[5]), .debug_branch_in(ev[6]),
    .branch_back_in(br), .system_access_in(ev[7]),
    .system_done_in(ev[8]), .system_abort_in(ev[9]),
    .data_pin_in(pd), .data_in_enable_n_in(cl[0]),
    .data_out_enable_n_in(cl[1]), .locked_transfer_in(cl[2]),
    .endianness_select_in(cl[3]), .data_bus_drive_enable_in(cl[4]),
    .access_size_in(cl[6:5]), .byte_latch_enable_in(cl[10:7]),
    .misc_cells_in(mc), .address_in(adr), .data_pin_out(dpo),
    .data_pin_oe_n_out(oen), .pc_out(pc), .debug_ack_out(ack),
    .core_mode_out(mode), .irq_disable_out(idis),
    .irq_remembered_out(irem), .abort_remembered_out(arem),
    .prefetch_abort_take_out(ptk));
  dbgpri_tap_model tap (.tck_out(tck), .tms_out(tms), .tdi_out(tdi),
    .tdo_in(tdo));

  // ==========================================================================
  // Clock, and a ceiling far above the several hundred cycles the run needs.
  initial
  begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      results();
    end
  end

  task automatic chk1(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask : chk1

  task automatic chkw(input string n, input logic [104:0] e,
                      input logic [104:0] g);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chkw

  // Events go up for exactly one edge; the answer is read one edge on.
  task automatic step(input logic [10:0] e);
    @(posedge clk) ev <= e;
    @(posedge clk) ev <= 11'h000;
    #1;
  endtask : step

  task automatic wack(input logic v);
    for (int i = 0; i < 40 && ack !== v; i++)
      @(posedge clk) #1;
    chk1("debug_ack_out", v, ack);
  endtask : wack

  // ==========================================================================
  // Scenarios.
  task automatic t_break();
    @(posedge clk) irq <= 1'b1;
    step(FV | BP);
    ep = ep + 32'h4;
    chkw("pc_out", ep, pc);
    chk1("debug_ack_out", 1'b1, ack);
    chk1("irq_disable_out", 1'b1, idis);
    chk1("core_mode_out", 1'b0, mode[1] | mode[0]);
    chk1("irq_remembered_out", 1'b0, irem);
    step(DI);
    step(DI);
    ep = ep + 32'h2;
    chkw("pc_out", ep, pc);
    step(SA);
    ep = ep + 32'h3;
    chkw("pc_out", ep, pc);
    chk1("debug_ack_out", 1'b0, ack);
    step(SD);
    chk1("debug_ack_out", 1'b1, ack);
    @(posedge clk) br <= 32'd10;
    step(DB);
    ep = ep - 32'd10;
    chkw("pc_out", ep, pc);
    tap.ir(IR_RESTART);
    wack(1'b0);
  endtask : t_break

  task automatic t_request();
    @(posedge clk) dreq <= 1'b1;
    wack(1'b1);
    @(posedge clk) dreq <= 1'b0;
    #1 ep = ep + 32'h3;
    chkw("pc_out", ep, pc);
    chkw("core_mode_out", 32'h1, mode);
    chk1("irq_remembered_out", 1'b1, irem);
    step(DI);
    step(SA);
    step(SB);
    chkw("core_mode_out", 32'h2, mode);
    chk1("debug_ack_out", 1'b0, ack);
    @(posedge clk) #1;
    chk1("debug_ack_out", 1'b1, ack);
    ep = ep + 32'h4;
    chkw("pc_out", ep, pc);
    @(posedge clk) br <= 32'd8;
    step(DB);
    ep = ep - 32'd8;
    chkw("pc_out", ep, pc);
    tap.ir(IR_RESTART);
    wack(1'b0);
    step(EA);
    chk1("irq_remembered_out", 1'b0, irem);
    @(posedge clk) irq <= 1'b0;
  endtask : t_request

  task automatic t_watch();
    step(WP | DA);
    chkw("core_mode_out", 32'h2, mode);
    chk1("abort_remembered_out", 1'b1, arem);
    chk1("debug_ack_out", 1'b0, ack);
    @(posedge clk) #1;
    chk1("debug_ack_out", 1'b1, ack);
    ep = ep + 32'h3;
    chkw("pc_out", ep, pc);
    tap.ir(IR_RESTART);
    wack(1'b0);
    @(posedge clk) irq <= 1'b1;
    step(WP);
    chkw("core_mode_out", 32'h1, mode);
    chk1("irq_remembered_out", 1'b1, irem);
    chk1("debug_ack_out", 1'b0, ack);
    @(posedge clk) irq <= 1'b0;
    #1 ep = ep + 32'h3;
    chkw("pc_out", ep, pc);
    chk1("debug_ack_out", 1'b1, ack);
    tap.ir(IR_RESTART);
    wack(1'b0);
    step(WP);
    ep = ep + 32'h4;
    chkw("pc_out", ep, pc);
    chk1("debug_ack_out", 1'b1, ack);
    tap.ir(IR_RESTART);
    wack(1'b0);
  endtask : t_watch

  task automatic t_pabt();
    step(FV | BP | PA);
    chk1("prefetch_abort_take_out", 1'b1, ptk);
    chk1("debug_ack_out", 1'b0, ack);
    @(posedge clk) #1;
    chk1("prefetch_abort_take_out", 1'b0, ptk);
    step(FV | BP);
    chk1("debug_ack_out", 1'b1, ack);
    tap.ir(IR_RESTART);
    wack(1'b0);
  endtask : t_pabt

  task automatic t_scan();
    logic [104:0] e, q, v;
    @(posedge clk) pd <= 32'hc3a5_0f96;
    cl <= 11'h4d5;
    mc <= 29'h0aaa_aaaa;
    adr <= 32'h8765_4321;
    #1;
    e = {32'h0, mc, cl, 1'b0, pd};
    for (int k = 0; k < 32; k++)
      e[73 + k] = adr[31 - k];
    v = 105'h0;
    v[31:0] = 32'h5a5a_0ff0;
    tap.ir(IR_EXTEST);
    tap.dr(v, q);
    chkw("boundary capture", e, q);
    chkw("data_pin_out", 32'h5a5a_0ff0, dpo);
    chk1("data_pin_oe_n_out", 1'b0, oen);
  endtask : t_scan

  task automatic results();
    $display("Checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  // ==========================================================================
  // Main sequence.
  initial
  begin
    // The scan half sees reset only through its own clock, so the
    // debugger walks its controller while reset is still high.
    fork
      begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
      end
      begin
        #1;
        tap.reset();
      end
    join
    #1;
    chkw("pc_out", 32'h0, pc);
    chk1("debug_ack_out", 1'b0, ack);
    chk1("data_pin_oe_n_out", 1'b1, oen);
    t_break();
    t_request();
    t_watch();
    t_pabt();
    t_scan();
    results();
  end
endmodule : test_dbgpri_core
`default_nettype wire
